// ### rtl/spr_pkg.sv
// constants and types of the serial port and radio control port block
package spr_pkg;
  localparam logic [7:0] ADDR_SER_DATA = 8'h90;
  localparam logic [7:0] ADDR_DRIVE = 8'h93;
  localparam logic [7:0] ADDR_SER_DIR = 8'h96;
  localparam logic [7:0] ADDR_SER_ALT = 8'h97;
  localparam logic [7:0] ADDR_RADIO = 8'hA0;
  localparam logic [7:0] ADDR_ROUTE = 8'hB3;
  localparam logic [3:0] RST_SER_DATA = 4'hF;
  localparam logic [3:0] RST_SER_DIR = 4'h4;
  localparam logic [3:0] RST_SER_ALT = 4'h0;
  localparam logic [7:0] RST_DRIVE = 8'h00;
  localparam logic [7:0] RST_RADIO = 8'h04;
  localparam logic [1:0] RST_ROUTE = 2'h0;
  localparam logic [1:0] ROUTE_PINS = 2'h1;
  // serial pin indices
  localparam int PIN_CLK = 0;
  localparam int PIN_DOUT = 1;
  localparam int PIN_DIN = 2;
  localparam int PIN_CS = 3;
  // radio register bits
  localparam int RB_MATCH = 7;
  localparam int RB_CARRIER = 6;
  localparam int RB_READY = 5;
  localparam int RB_EOC = 4;
  localparam int RB_SOUT = 2;
  localparam int RB_ENABLE = 5;
  localparam int RB_TXSEL = 4;
  localparam int RB_SSEL = 3;
  localparam int RB_SIN = 1;
  localparam int RB_SCLK = 0;

  typedef struct packed {
    logic sclk;
    logic mosi;
    logic csn;
  } spr_spi_t;

  typedef struct packed {
    logic address_match;
    logic carrier_detect;
    logic data_ready_flag;
    logic end_of_conv;
    logic radio_serial_out;
  } spr_status_t;

  typedef struct packed {
    logic radio_enable;
    logic tx_select;
    logic radio_serial_select;
    logic radio_serial_in;
    logic radio_serial_clock;
  } spr_radio_t;
endpackage : spr_pkg

// ### rtl/spr_sync.sv
// two-stage synchroniser, one per bit
`timescale 1ns/1ns
module spr_sync #(
  parameter int WIDTH = 4
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] next_stage1;
  logic [WIDTH-1:0] next_sync_out;

  always_comb begin
    next_stage1 = rstn ? async_in : '0;
    next_sync_out = rstn ? stage1 : '0;
  end

  always_ff @(posedge clock) begin
    stage1 <= next_stage1;
    sync_out <= next_sync_out;
  end
endmodule : spr_sync

// ### rtl/spr_port.sv
// serial port, high-drive control and radio control port
`timescale 1ns/1ns
module spr_port (
  input wire logic clock,
  input wire logic rstn,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  input wire logic [3:0] ser_pin_in,
  output logic [3:0] ser_pin_out,
  output logic [3:0] ser_pin_oe,
  output logic timer2_input,
  input wire spr_pkg::spr_spi_t spi_master,
  output logic spi_miso,
  output logic [7:0] drive_source_hi,
  output logic [7:0] drive_sink_hi,
  input wire spr_pkg::spr_status_t radio_status,
  output spr_pkg::spr_radio_t radio_ctrl
);
  import spr_pkg::*;

  // ********************************
  // registers
  // ********************************
  logic [3:0] ser_data, next_ser_data;
  logic [3:0] ser_dir, next_ser_dir;
  logic [3:0] ser_alt, next_ser_alt;
  logic [7:0] first_port_high_drive, next_first_port_high_drive;
  logic [7:0] radio_reg, next_radio_reg;
  logic [1:0] route, next_route;
  logic [3:0] pin_sync;
  logic [4:0] stat_sync;

  always_comb begin
    next_ser_data = ser_data;
    next_ser_dir = ser_dir;
    next_ser_alt = ser_alt;
    next_first_port_high_drive = first_port_high_drive;
    next_radio_reg = radio_reg;
    next_route = route;
    if (!rstn) begin
      next_ser_data = RST_SER_DATA;
      next_ser_dir = RST_SER_DIR;
      next_ser_alt = RST_SER_ALT;
      next_first_port_high_drive = RST_DRIVE;
      next_radio_reg = RST_RADIO;
      next_route = RST_ROUTE;
    end else if (sfr_wr) begin
      case (sfr_addr)
        ADDR_SER_DATA: next_ser_data = sfr_wdata[3:0];
        ADDR_SER_DIR: next_ser_dir = sfr_wdata[3:0];
        ADDR_SER_ALT: next_ser_alt = sfr_wdata[3:0];
        ADDR_DRIVE: next_first_port_high_drive = sfr_wdata;
        ADDR_RADIO: next_radio_reg = sfr_wdata;
        ADDR_ROUTE: next_route = sfr_wdata[1:0];
        default: next_ser_data = ser_data;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    ser_data <= next_ser_data;
    ser_dir <= next_ser_dir;
    ser_alt <= next_ser_alt;
    first_port_high_drive <= next_first_port_high_drive;
    radio_reg <= next_radio_reg;
    route <= next_route;
  end

  // ********************************
  // pin and status synchronisers
  // ********************************
  spr_sync #(.WIDTH(4)) u_pin_sync (
    .clock(clock),
    .rstn(rstn),
    .async_in(ser_pin_in),
    .sync_out(pin_sync)
  );

  // transceiver status sits in another block, so it is synchronised too
  spr_sync #(.WIDTH(5)) u_stat_sync (
    .clock(clock),
    .rstn(rstn),
    .async_in(radio_status),
    .sync_out(stat_sync)
  );

  spr_status_t st;
  assign st = stat_sync;

  // ********************************
  // serial port pins
  // ********************************
  logic spi_on;
  logic radio_spi;
  assign spi_on = (route == ROUTE_PINS);
  assign radio_spi = route[1];

  always_comb begin
    ser_pin_out = ser_data;
    ser_pin_oe = ~ser_dir;
    if (spi_on) begin
      ser_pin_out[PIN_CLK] = spi_master.sclk;
      ser_pin_out[PIN_DOUT] = spi_master.mosi;
      ser_pin_oe[PIN_CLK] = 1'b1;
      ser_pin_oe[PIN_DOUT] = 1'b1;
      ser_pin_oe[PIN_CS] = 1'b1;
    end else if (ser_alt[PIN_CLK]) begin
      ser_pin_oe[PIN_CLK] = 1'b0;
    end
    // outside spi routing, bits 1 and 3 keep their direction bits whatever alt says
    ser_pin_oe[PIN_DIN] = 1'b0;
    ser_pin_out[PIN_CS] = ser_data[PIN_CS];
  end

  assign timer2_input = !spi_on && ser_alt[PIN_CLK] && pin_sync[PIN_CLK];

  // ********************************
  // high drive and radio lines
  // ********************************
  genvar i;
  generate
    for (i = 0; i < 8; i++) begin : g_drive
      if (i % 2 == 1) begin : g_odd
        assign drive_source_hi[i] = first_port_high_drive[i];
        assign drive_sink_hi[i] = 1'b0;
      end else begin : g_even
        assign drive_source_hi[i] = 1'b0;
        assign drive_sink_hi[i] = first_port_high_drive[i];
      end
    end
  endgenerate

  always_comb begin
    radio_ctrl.radio_enable = radio_reg[RB_ENABLE];
    radio_ctrl.tx_select = radio_reg[RB_TXSEL];
    if (radio_spi) begin
      radio_ctrl.radio_serial_select = spi_master.csn;
      radio_ctrl.radio_serial_in = spi_master.mosi;
      radio_ctrl.radio_serial_clock = spi_master.sclk;
    end else begin
      radio_ctrl.radio_serial_select = radio_reg[RB_SSEL];
      radio_ctrl.radio_serial_in = radio_reg[RB_SIN];
      radio_ctrl.radio_serial_clock = radio_reg[RB_SCLK];
    end
    // master reads the radio when route bit 1 is set, the data-in pin otherwise
    if (radio_spi) begin
      spi_miso = st.radio_serial_out;
    end else begin
      spi_miso = pin_sync[PIN_DIN];
    end
  end

  // ********************************
  // read mux
  // ********************************
  logic [7:0] next_rdata;
  always_comb begin
    next_rdata = 8'h00;
    case (sfr_addr)
      ADDR_SER_DATA: next_rdata = {4'h0, pin_sync};
      ADDR_SER_DIR: next_rdata = {4'h0, ser_dir};
      ADDR_SER_ALT: next_rdata = {4'h0, ser_alt};
      ADDR_DRIVE: next_rdata = first_port_high_drive;
      ADDR_RADIO: begin
        next_rdata[RB_MATCH] = st.address_match;
        next_rdata[RB_CARRIER] = st.carrier_detect;
        next_rdata[RB_READY] = st.data_ready_flag;
        next_rdata[RB_EOC] = st.end_of_conv;
        next_rdata[RB_SOUT] = st.radio_serial_out;
      end
      ADDR_ROUTE: next_rdata = {6'h00, route};
      default: next_rdata = 8'h00;
    endcase
    if (!rstn) begin
      next_rdata = 8'h00;
    end
  end

  always_ff @(posedge clock) begin
    sfr_rdata <= next_rdata;
  end

  // ********************************
  // checks
  // ********************************
  sequence data_wr_s;
    sfr_wr && sfr_addr == ADDR_SER_DATA;
  endsequence
  sequence dir_wr_s;
    sfr_wr && sfr_addr == ADDR_SER_DIR;
  endsequence
  sequence alt_wr_s;
    sfr_wr && sfr_addr == ADDR_SER_ALT;
  endsequence
  sequence drive_wr_s;
    sfr_wr && sfr_addr == ADDR_DRIVE;
  endsequence
  sequence radio_wr_s;
    sfr_wr && sfr_addr == ADDR_RADIO;
  endsequence
  sequence route_wr_s;
    sfr_wr && sfr_addr == ADDR_ROUTE;
  endsequence
  sequence radio_rd_s;
    sfr_addr == ADDR_RADIO;
  endsequence
  // a radio write that no spi routing overrides one cycle later
  sequence bitbang_wr_s;
    radio_wr_s ##1 !radio_spi;
  endsequence

  din_input_a: assert property (@(posedge clock) disable iff (!rstn)
    ser_pin_oe[PIN_DIN] == 1'b0) else $error("data-in pin driven");
  spi_route_a: assert property (@(posedge clock) disable iff (!rstn)
    spi_on |-> ser_pin_oe[PIN_CLK] && ser_pin_out[PIN_CLK] == spi_master.sclk)
    else $error("clock pin not owned by spi");
  clk_gpio_a: assert property (@(posedge clock) disable iff (!rstn)
    !spi_on && !ser_alt[PIN_CLK] |-> ser_pin_oe[PIN_CLK] == !ser_dir[PIN_CLK])
    else $error("clock pin gpio direction wrong");
  t2_input_a: assert property (@(posedge clock) disable iff (!rstn)
    !spi_on && ser_alt[PIN_CLK] |-> !ser_pin_oe[PIN_CLK])
    else $error("timer input pin driven");
  own_dir_a: assert property (@(posedge clock) disable iff (!rstn)
    !spi_on |-> ser_pin_oe[PIN_DOUT] == !ser_dir[PIN_DOUT] && ser_pin_oe[PIN_CS] == !ser_dir[PIN_CS]
      && ser_pin_out[PIN_CS] == ser_data[PIN_CS])
    else $error("bit 1 or 3 direction wrong");
  drive_map_a: assert property (@(posedge clock) disable iff (!rstn)
    drive_source_hi[1] == first_port_high_drive[1] && drive_sink_hi[0] == first_port_high_drive[0])
    else $error("high drive map wrong");
  radio_override_a: assert property (@(posedge clock) disable iff (!rstn)
    radio_spi |-> radio_ctrl.radio_serial_clock == spi_master.sclk)
    else $error("spi not overriding radio clock");
  radio_write_a: assert property (@(posedge clock) disable iff (!rstn)
    radio_wr_s |=> radio_ctrl.radio_enable == $past(sfr_wdata[RB_ENABLE]))
    else $error("radio enable not written");
  reset_vals_a: assert property (@(posedge clock)
    !rstn |=> radio_reg == RST_RADIO && route == RST_ROUTE && first_port_high_drive == RST_DRIVE)
    else $error("reset values wrong");
  status_read_a: assert property (@(posedge clock) disable iff (!rstn)
    radio_rd_s |=> sfr_rdata[3] == 1'b0 && sfr_rdata[1:0] == 2'h0)
    else $error("unused status bits set");
  spi_dout_a: assert property (@(posedge clock) disable iff (!rstn)
    spi_on |-> ser_pin_oe[PIN_DOUT] && ser_pin_oe[PIN_CS]
      && ser_pin_out[PIN_DOUT] == spi_master.mosi)
    else $error("data-out or select pin not set up for spi");
  cs_gpio_a: assert property (@(posedge clock) disable iff (!rstn)
    ser_pin_out[PIN_CS] == ser_data[PIN_CS])
    else $error("eeprom select not driven from data register");
  t2_quiet_a: assert property (@(posedge clock) disable iff (!rstn)
    spi_on || !ser_alt[PIN_CLK] |-> !timer2_input)
    else $error("timer input active without alternate function");
  t2_follow_a: assert property (@(posedge clock) disable iff (!rstn)
    !spi_on && ser_alt[PIN_CLK] |-> timer2_input == pin_sync[PIN_CLK])
    else $error("timer input not following clock pin");
  drive_high_a: assert property (@(posedge clock) disable iff (!rstn)
    drive_source_hi[7] == first_port_high_drive[7] && !drive_sink_hi[7]
      && drive_sink_hi[6] == first_port_high_drive[6] && !drive_source_hi[6])
    else $error("high drive of pins 6 and 7 wrong");
  data_write_a: assert property (@(posedge clock) disable iff (!rstn)
    data_wr_s |=> ser_data == $past(sfr_wdata[3:0]))
    else $error("serial data write lost");
  dir_write_a: assert property (@(posedge clock) disable iff (!rstn)
    dir_wr_s |=> ser_dir == $past(sfr_wdata[3:0]))
    else $error("serial direction write lost");
  alt_write_a: assert property (@(posedge clock) disable iff (!rstn)
    alt_wr_s |=> ser_alt == $past(sfr_wdata[3:0]))
    else $error("serial alternate write lost");
  drive_write_a: assert property (@(posedge clock) disable iff (!rstn)
    drive_wr_s |=> first_port_high_drive == $past(sfr_wdata))
    else $error("high drive write lost");
  route_write_a: assert property (@(posedge clock) disable iff (!rstn)
    route_wr_s |=> route == $past(sfr_wdata[1:0]))
    else $error("routing select write lost");
  txsel_write_a: assert property (@(posedge clock) disable iff (!rstn)
    radio_wr_s |=> radio_ctrl.tx_select == $past(sfr_wdata[RB_TXSEL]))
    else $error("transmit select not written");
  bitbang_out_a: assert property (@(posedge clock) disable iff (!rstn)
    bitbang_wr_s |-> radio_ctrl.radio_serial_select == $past(sfr_wdata[RB_SSEL])
      && radio_ctrl.radio_serial_in == $past(sfr_wdata[RB_SIN])
      && radio_ctrl.radio_serial_clock == $past(sfr_wdata[RB_SCLK]))
    else $error("bit-bang radio lines not written");
  radio_spi_a: assert property (@(posedge clock) disable iff (!rstn)
    radio_spi |-> radio_ctrl.radio_serial_select == spi_master.csn
      && radio_ctrl.radio_serial_in == spi_master.mosi)
    else $error("spi not overriding radio select or data");
  radio_hold_a: assert property (@(posedge clock) disable iff (!rstn)
    !(sfr_wr && sfr_addr == ADDR_RADIO) |=> $stable(radio_reg))
    else $error("radio port changed without a write");
  read_status_a: assert property (@(posedge clock) disable iff (!rstn)
    radio_rd_s |=> sfr_rdata[RB_MATCH] == $past(st.address_match)
      && sfr_rdata[RB_CARRIER] == $past(st.carrier_detect)
      && sfr_rdata[RB_READY] == $past(st.data_ready_flag))
    else $error("radio status flags misplaced");
  read_conv_a: assert property (@(posedge clock) disable iff (!rstn)
    radio_rd_s |=> sfr_rdata[RB_EOC] == $past(st.end_of_conv)
      && sfr_rdata[RB_SOUT] == $past(st.radio_serial_out))
    else $error("conversion or serial out bit misplaced");
  upper_zero_a: assert property (@(posedge clock) disable iff (!rstn)
    sfr_addr == ADDR_SER_DATA || sfr_addr == ADDR_SER_DIR || sfr_addr == ADDR_SER_ALT
      |=> sfr_rdata[7:4] == 4'h0)
    else $error("unused serial register bits read back");
  ser_reset_a: assert property (@(posedge clock)
    !rstn |=> ser_data == RST_SER_DATA && ser_dir == RST_SER_DIR && ser_alt == RST_SER_ALT
      && sfr_rdata == 8'h00)
    else $error("serial reset values wrong");
  pin_sync_a: assert property (@(posedge clock) disable iff (!rstn)
    $past(rstn, 2) && $past(rstn) |-> pin_sync == $past(ser_pin_in, 2))
    else $error("pin read not two cycles behind the pin");
  status_sync_a: assert property (@(posedge clock) disable iff (!rstn)
    $past(rstn, 2) && $past(rstn) |-> stat_sync == $past(radio_status, 2))
    else $error("status read not two cycles behind the line");
endmodule : spr_port

// ### verification/spr_far_side.sv
// far-side model: serial pin wiring and radio status lines
`timescale 1ns/1ns
module spr_far_side (
  input wire logic [3:0] ser_pin_out,
  input wire logic [3:0] ser_pin_oe,
  input wire logic [3:0] ext_level,
  input wire spr_pkg::spr_status_t status_in,
  output logic [3:0] ser_pin_in,
  output spr_pkg::spr_status_t radio_status
);
  import spr_pkg::*;
  // **********
  // pin levels
  // **********
  // undriven pins follow the external device; the bench changes it every pass
  assign ser_pin_in = (ser_pin_oe & ser_pin_out) | (~ser_pin_oe & ext_level);
  assign radio_status = status_in;
endmodule : spr_far_side

// ### verification/tb_spr_port.sv
// self-checking bench of the serial and radio control port
`timescale 1ns/1ns
module tb_spr_port;
  import spr_pkg::*;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic sfr_wr = 1'b0;
  logic [7:0] sfr_addr = 8'h00;
  logic [7:0] sfr_wdata = 8'h00;
  logic [7:0] sfr_rdata, drive_source_hi, drive_sink_hi, dv, rp, w;
  logic [3:0] ser_pin_in, ser_pin_out, ser_pin_oe, d, di, al, eo, p;
  logic [3:0] ext = 4'h0;
  logic [1:0] rt;
  logic timer2_input, spi_miso;
  spr_spi_t spi_master = '0;
  spr_status_t st = '0;
  spr_status_t radio_status;
  spr_radio_t radio_ctrl;
  int error_cnt = 0;
  int tests_run = 0;
  int seed = 26598;
  always #20 clock = ~clock;
  spr_port spr_port_inst (.clock(clock), .rstn(rstn), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .ser_pin_in(ser_pin_in),
    .ser_pin_out(ser_pin_out), .ser_pin_oe(ser_pin_oe), .timer2_input(timer2_input),
    .spi_master(spi_master), .spi_miso(spi_miso), .drive_source_hi(drive_source_hi),
    .drive_sink_hi(drive_sink_hi), .radio_status(radio_status), .radio_ctrl(radio_ctrl));
  spr_far_side spr_far_side_inst (.ser_pin_out(ser_pin_out), .ser_pin_oe(ser_pin_oe),
    .ext_level(ext), .status_in(st), .ser_pin_in(ser_pin_in), .radio_status(radio_status));
  // **********
  // expectations
  // **********
  function automatic logic [3:0] e_oe(logic [3:0] dir, logic [3:0] alt, logic [1:0] r);
    if (r == ROUTE_PINS) return 4'hB;
    return {~dir[3], 1'b0, ~dir[1], ~dir[0] & ~alt[0]};
  endfunction : e_oe
  function automatic logic [3:0] e_out(logic [3:0] dat, logic [1:0] r, spr_spi_t s);
    if (r == ROUTE_PINS) return {dat[3], dat[2], s.mosi, s.sclk};
    return dat;
  endfunction : e_out
  function automatic logic [7:0] e_radio(logic [7:0] v, logic [1:0] r, spr_spi_t s);
    if (r[1]) return {3'h0, v[5], v[4], s.csn, s.mosi, s.sclk};
    return {3'h0, v[5], v[4], v[3], v[1], v[0]};
  endfunction : e_radio
  task automatic chk(logic [7:0] got, logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(logic [7:0] a, logic [7:0] v);
    @(negedge clock);
    sfr_addr = a;
    sfr_wdata = v;
    sfr_wr = 1'b1;
    @(negedge clock);
    sfr_wr = 1'b0;
  endtask : wr
  task automatic rd(logic [7:0] a, logic [7:0] e);
    @(negedge clock);
    sfr_addr = a;
    @(negedge clock);
    chk(sfr_rdata, e);
  endtask : rd
  task automatic conclude();
    $display("errors=%0d checks=%0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : conclude
  initial begin
    #400000;
    error_cnt++;
    conclude();
  end
  initial begin
    repeat (5) @(negedge clock);
    rstn = 1'b1;
    chk({3'h0, radio_ctrl}, 8'h00);
    chk({4'h0, ser_pin_oe}, 8'h0B);
    chk({4'h0, ser_pin_out & 4'hB}, 8'h0B);
    rd(ADDR_SER_DIR, 8'h04);
    rd(ADDR_SER_ALT, 8'h00);
    rd(ADDR_DRIVE, 8'h00);
    rd(ADDR_ROUTE, 8'h00);
    for (int i = 0; i < 40; i++) begin
      ext = 4'($random(seed));
      st = 5'($random(seed));
      spi_master = 3'($random(seed));
      rt = (i < 4) ? i[1:0] : 2'($random(seed));
      // software normally uses the spi master; bit-bang passes cover route 0x
      w = 8'($random(seed));
      d = w[3:0];
      wr(ADDR_SER_DATA, w);
      w = 8'($random(seed));
      di = w[3:0];
      wr(ADDR_SER_DIR, w);
      w = (i < 2) ? 8'hFF : 8'($random(seed));
      al = w[3:0];
      wr(ADDR_SER_ALT, w);
      dv = 8'($random(seed));
      wr(ADDR_DRIVE, dv);
      rp = 8'($random(seed));
      wr(ADDR_RADIO, rp);
      wr(ADDR_ROUTE, {6'($random(seed)), rt});
      repeat (3) @(negedge clock);
      eo = e_oe(di, al, rt);
      p = (eo & e_out(d, rt, spi_master)) | (~eo & ext);
      chk({4'h0, ser_pin_oe}, {4'h0, eo});
      chk({4'h0, ser_pin_out & eo}, {4'h0, e_out(d, rt, spi_master) & eo});
      chk({7'h0, timer2_input}, {7'h0, (al[0] && rt != ROUTE_PINS) & p[0]});
      chk({7'h0, spi_miso}, {7'h0, rt[1] ? st.radio_serial_out : p[2]});
      chk(drive_source_hi, dv & 8'hAA);
      chk(drive_sink_hi, dv & 8'h55);
      chk({3'h0, radio_ctrl}, e_radio(rp, rt, spi_master));
      rd(ADDR_SER_DATA, {4'h0, p});
      rd(ADDR_SER_DIR, {4'h0, di});
      rd(ADDR_SER_ALT, {4'h0, al});
      rd(ADDR_DRIVE, dv);
      rd(ADDR_ROUTE, {6'h0, rt});
      rd(ADDR_RADIO, {st[4:1], 1'b0, st[0], 2'h0});
    end
    // reset in mid-run: everything written in the loop must fall back to its default
    rstn = 1'b0;
    repeat (3) @(negedge clock);
    rstn = 1'b1;
    chk({3'h0, radio_ctrl}, 8'h00);
    chk({4'h0, ser_pin_oe}, 8'h0B);
    chk({4'h0, ser_pin_out & 4'hB}, 8'h0B);
    rd(ADDR_SER_DIR, 8'h04);
    rd(ADDR_SER_ALT, 8'h00);
    rd(ADDR_DRIVE, 8'h00);
    rd(ADDR_ROUTE, 8'h00);
    rd(ADDR_SER_DATA, {4'h0, 1'b1, ext[2], 2'h3});
    rd(8'h91, 8'h00);
    conclude();
  end
endmodule : tb_spr_port
